// ---- hdl/bcg_pkg.sv ----
`default_nettype none
package bcg_pkg;
    // source numbering seen by every selector
    localparam int NUM_SRC = 12;
    localparam int SRC_RING = 0;
    localparam int SRC_XTAL = 1;
    localparam int SRC_PLL0 = 2;
    localparam int SRC_PLL1 = 3;
    localparam int SRC_PLL2 = 4;
    localparam int SRC_FDIV0 = 5;
    localparam int SEL_W = 4;
    // output generator numbering
    localparam int NUM_OUT = 12;
    localparam int NUM_FDIV = 7;
    localparam int OUT_SAFE = 0;
    localparam int OUT_SYS = 1;
    localparam int OUT_CTRL = 2;
    localparam int OUT_FEED_A = 5;
    localparam int OUT_RSVD = 10;
    localparam int OUT_FEED_B = 11;
    // timing
    localparam int DET_WINDOW = 32;
    localparam int SYNC_CYC = 2;
    localparam int CLK_MHZ = 200;
    localparam int PLL_LOCK_US_DEF = 100;
    // register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_PRES = 8'h00;
    localparam logic [7:0] OFF_EVT = 8'h04;
    localparam logic [7:0] OFF_PLLCTL = 8'h08;
    localparam logic [7:0] OFF_PLLSTS = 8'h0c;
    localparam logic [7:0] OFF_USB = 8'h10;
    localparam logic [7:0] OFF_CH = 8'h40;
    // fields
    localparam int PRES_VALID_BIT = 16;
    localparam int EVT_FALL_LSB = 16;
    localparam int PD_BIT = 0;
    localparam int DIRECT_BIT = 1;
    localparam int PSEL_LSB = 2;
    localparam int EXTRA_PHASE_ENABLE_BIT = 4;
    localparam int MSEL_LSB = 8;
    localparam int MSEL_W = 8;
    localparam int LOCK_BIT = 0;
    localparam int PSYNC_BIT = 1;
    localparam int OFF_BIT = 8;
    localparam int BUSY_BIT = 16;
    // reset values
    localparam logic PD_RST = 1'b1;
    localparam logic [7:0] MSEL_RST = 8'h01;
    localparam logic [4:0] POST_DIV_BASE = 5'h02;
    typedef enum logic [2:0] {
        SW_RUN = 3'b001,
        SW_STOP = 3'b010,
        SW_HOLD = 3'b100
    } bcg_sw_t;
endpackage
`default_nettype wire

// ---- hdl/bcg_act_det.sv ----
`timescale 1ns/1ps
`default_nettype none
module bcg_act_det #(
    parameter int WINDOW = bcg_pkg::DET_WINDOW
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic src_lvl,
    output logic active,
    output logic rise_evt,
    output logic fall_evt
);
    import bcg_pkg::*;
    localparam int CW = $clog2(WINDOW);
    logic prev;
    logic [CW-1:0] cnt;
    logic edge_seen;

    assign edge_seen = src_lvl && !prev;

    // previous sample for rising edge detection
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 1'b0;
        end else begin
            prev <= src_lvl;
        end
    end

    // starts absent; one edge marks active, a silent window marks inactive
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            active <= 1'b0;
            rise_evt <= 1'b0;
            fall_evt <= 1'b0;
        end else begin
            rise_evt <= edge_seen && !active;
            fall_evt <= 1'b0;
            if (edge_seen) begin
                cnt <= '0;
                active <= 1'b1;
            end else if (cnt == CW'(WINDOW - 1)) begin
                fall_evt <= active;
                active <= 1'b0;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end

    silent_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cnt == CW'(WINDOW - 1) && !edge_seen) |=> !active)
        else $error("source not dropped after silent window");
    edge_mark_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (edge_seen && !active) |=> (active && rise_evt))
        else $error("edge did not mark source active");
endmodule
`default_nettype wire

// ---- hdl/bcg_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Function
// - outputs 0..11: 0 safe, 1 system, 2 control, 5/11 usb feeds, 10 reserved
// - safe and control outputs run only from the ring oscillator
// - the ring oscillator has no power-down control at all
// - other outputs but the reserved one select a divider, any pll phase, ring or crystal
// - dividers take a pll phase, ring or crystal; pll input is crystal
// - illegal select keeps old select field, other fields still written
// - every selector picks the ring oscillator after reset
// - selects naming an absent source are masked per live presence status
// - detector: no rising edge in 32 cycles means inactive, one edge active
// - presence reads all absent after reset, valid after 32 cycles
// - detectors flag both activation and deactivation, selected or not
// - source switches are glitch-free with a short forced-low gap
// - switching onto the pll holds the clock low until lock
// - current clock stuck high 32 cycles during switch is forced low
// - pll feedback divides by programmable factor; lock is reported
// - extra phase enable turns on two more phases 120 degrees apart
// - extra phases free-run before lock, synchronised after lock
// - post divide 2/4/8/16 by two-bit select, or undivided when direct
// - pll power-down keeps lock low; lock returns after relock
// - all unit logic runs on the always-on control clock
// - usb unit pll takes one feed clock; the other drives direct output
module bcg_top #(
    parameter int PLL_LOCK_US = bcg_pkg::PLL_LOCK_US_DEF
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [bcg_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [bcg_pkg::NUM_SRC-1:0] src_lvl,
    output logic [bcg_pkg::NUM_OUT-1:0] base_clk,
    output logic [bcg_pkg::NUM_FDIV-1:0] fdiv_in_clk,
    output logic pll_ref_clk,
    output logic pll_power_down,
    output logic pll_direct,
    output logic [4:0] pll_post_div,
    output logic [7:0] pll_fb_div,
    output logic pll_lock,
    output logic pll_phase_sync,
    output logic usb_pll_ref_clk,
    output logic usb_direct_clk
);
    import bcg_pkg::*;
    localparam int LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
    localparam int LOCK_W = $clog2(LOCK_CYC + 1);
    localparam int NCH = NUM_OUT + NUM_FDIV;

    logic [NUM_SRC-1:0] det_act;
    logic [NUM_SRC-1:0] det_rise;
    logic [NUM_SRC-1:0] det_fall;
    logic [NUM_SRC-1:0] present;
    logic [NUM_SRC-1:0] evt_rise;
    logic [NUM_SRC-1:0] evt_fall;
    logic [5:0] vcnt;
    logic pres_valid;
    logic extra_phase_enable;
    logic [1:0] post_sel;
    logic [LOCK_W-1:0] lock_cnt;
    logic usb_sel;
    logic [NCH*SEL_W-1:0] req_v;
    logic [NCH-1:0] off_v;
    logic [NCH-1:0] busy_v;
    logic [NCH-1:0] chan_v;
    logic wr;
    logic hit;
    logic [31:0] rd_val;
    logic [7:0] ch_off;
    logic [4:0] cidx;

    default clocking dflt_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // a select is legal only for a present source; dividers never chain
    function automatic logic sel_ok(input logic [SEL_W-1:0] s, input logic fd,
                                    input logic [NUM_SRC-1:0] p);
        sel_ok = (int'(s) < NUM_SRC) && !(fd && int'(s) > SRC_PLL2);
        if (sel_ok) begin
            sel_ok = p[s];
        end
    endfunction

    // one detector per source, all on the control clock
    genvar gi;
    for (gi = 0; gi < NUM_SRC; gi++) begin : det_g
        bcg_act_det #(.WINDOW(DET_WINDOW)) u_det (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .src_lvl(src_lvl[gi]),
            .active(det_act[gi]),
            .rise_evt(det_rise[gi]),
            .fall_evt(det_fall[gi])
        );
    end

    // live presence; the ring has no power-down so only pll phases are gated
    always_comb begin
        present = det_act & {NUM_SRC{pres_valid}};
        if (pll_power_down) begin
            present[SRC_PLL2:SRC_PLL0] = '0;
        end
        if (!extra_phase_enable) begin
            present[SRC_PLL2:SRC_PLL1] = '0;
        end
    end

    // presence is not trusted until one full detector window has passed
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            vcnt <= '0;
            pres_valid <= 1'b0;
        end else if (!pres_valid) begin
            vcnt <= vcnt + 1'b1;
            pres_valid <= (vcnt == 6'(DET_WINDOW - 1));
        end
    end

    // apb slave with one wait state; bridge side shares the control clock
    assign wr = psel && penable && pready && pwrite;
    assign ch_off = paddr - OFF_CH;
    assign cidx = ch_off[6:2];

    always_comb begin
        hit = 1'b1;
        rd_val = '0;
        if (paddr == OFF_PRES) begin
            rd_val[NUM_SRC-1:0] = present;
            rd_val[PRES_VALID_BIT] = pres_valid;
        end else if (paddr == OFF_EVT) begin
            rd_val[NUM_SRC-1:0] = evt_rise;
            rd_val[EVT_FALL_LSB +: NUM_SRC] = evt_fall;
        end else if (paddr == OFF_PLLCTL) begin
            rd_val[PD_BIT] = pll_power_down;
            rd_val[DIRECT_BIT] = pll_direct;
            rd_val[PSEL_LSB +: 2] = post_sel;
            rd_val[EXTRA_PHASE_ENABLE_BIT] = extra_phase_enable;
            rd_val[MSEL_LSB +: MSEL_W] = pll_fb_div;
        end else if (paddr == OFF_PLLSTS) begin
            rd_val[LOCK_BIT] = pll_lock;
            rd_val[PSYNC_BIT] = pll_phase_sync;
        end else if (paddr == OFF_USB) begin
            rd_val[0] = usb_sel;
        end else if (paddr >= OFF_CH && ch_off < 8'(4 * NCH) && paddr[1:0] == 2'b00) begin
            rd_val[SEL_W-1:0] = req_v[cidx*SEL_W +: SEL_W];
            rd_val[OFF_BIT] = off_v[cidx];
            rd_val[BUSY_BIT] = busy_v[cidx];
        end else begin
            hit = 1'b0;
        end
    end

    // answer registered so prdata and pready come straight from flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !hit;
            prdata <= pwrite ? 32'h0000_0000 : rd_val;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // sticky detector events, write one to clear; a new event beats the clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_rise <= '0;
            evt_fall <= '0;
        end else if (wr && paddr == OFF_EVT) begin
            evt_rise <= (evt_rise & ~pwdata[NUM_SRC-1:0]) | det_rise;
            evt_fall <= (evt_fall & ~pwdata[EVT_FALL_LSB +: NUM_SRC]) | det_fall;
        end else begin
            evt_rise <= evt_rise | det_rise;
            evt_fall <= evt_fall | det_fall;
        end
    end

    // pll control; starts powered down so nothing can pick it before software clears power-down
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_power_down <= PD_RST;
            pll_direct <= 1'b0;
            post_sel <= 2'b00;
            extra_phase_enable <= 1'b0;
            pll_fb_div <= MSEL_RST;
        end else if (wr && paddr == OFF_PLLCTL) begin
            pll_power_down <= pwdata[PD_BIT];
            pll_direct <= pwdata[DIRECT_BIT];
            post_sel <= pwdata[PSEL_LSB +: 2];
            extra_phase_enable <= pwdata[EXTRA_PHASE_ENABLE_BIT];
            pll_fb_div <= pwdata[MSEL_LSB +: MSEL_W];
        end
    end

    // post divide 2<<sel gives 2,4,8,16 with even duty; direct bypasses it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_post_div <= POST_DIV_BASE;
            pll_ref_clk <= 1'b0;
        end else begin
            pll_post_div <= pll_direct ? 5'h01 : (POST_DIV_BASE << post_sel);
            pll_ref_clk <= src_lvl[SRC_XTAL];
        end
    end

    // lock timer; a new feedback factor forces a relock
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_cnt <= '0;
            pll_lock <= 1'b0;
            pll_phase_sync <= 1'b0;
        end else begin
            if (pll_power_down || (wr && paddr == OFF_PLLCTL
                    && pwdata[MSEL_LSB +: MSEL_W] != pll_fb_div)) begin
                lock_cnt <= '0;
                pll_lock <= 1'b0;
            end else if (lock_cnt == LOCK_W'(LOCK_CYC - 1)) begin
                pll_lock <= 1'b1;
            end else begin
                lock_cnt <= lock_cnt + 1'b1;
            end
            // extra phase dividers realign to the main phase only once locked
            pll_phase_sync <= pll_lock && extra_phase_enable;
        end
    end

    // usb unit feed selection
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            usb_sel <= 1'b0;
            usb_pll_ref_clk <= 1'b0;
            usb_direct_clk <= 1'b0;
        end else begin
            if (wr && paddr == OFF_USB) begin
                usb_sel <= pwdata[0];
            end
            usb_pll_ref_clk <= usb_sel ? chan_v[OUT_FEED_B] : chan_v[OUT_FEED_A];
            usb_direct_clk <= usb_sel ? chan_v[OUT_FEED_A] : chan_v[OUT_FEED_B];
        end
    end

    assign base_clk = chan_v[NUM_OUT-1:0];
    assign fdiv_in_clk = chan_v[NCH-1:NUM_OUT];

    // one selector per output generator and per divider input
    genvar gc;
    for (gc = 0; gc < NCH; gc++) begin : ch_g
        localparam bit FIXED = (gc == OUT_SAFE) || (gc == OUT_CTRL) || (gc == OUT_RSVD);
        localparam bit IS_FD = (gc >= NUM_OUT);
        bcg_sw_t st;
        logic [SEL_W-1:0] rq;
        logic [SEL_W-1:0] cr;
        logic [5:0] cnt;
        logic of;
        logic ck;
        logic wsel;
        logic tgt_pll;

        assign wsel = wr && (paddr == 8'(OFF_CH + 4 * gc));
        assign tgt_pll = int'(rq) >= SRC_PLL0 && int'(rq) <= SRC_PLL2;
        assign req_v[gc*SEL_W +: SEL_W] = rq;
        assign off_v[gc] = of;
        assign busy_v[gc] = (st != SW_RUN);
        assign chan_v[gc] = ck;

        // select field only moves to a legal, present source
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                rq <= SEL_W'(SRC_RING);
                of <= 1'b0;
            end else if (wsel) begin
                if (!FIXED && sel_ok(pwdata[SEL_W-1:0], IS_FD, present)) begin
                    rq <= pwdata[SEL_W-1:0];
                end
                of <= FIXED ? 1'b0 : pwdata[OFF_BIT];
            end
        end

        // wait for the old clock to fall, hold low, then release the new one
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                st <= SW_RUN;
                cr <= SEL_W'(SRC_RING);
                cnt <= '0;
                ck <= 1'b0;
            end else begin
                case (st)
                    SW_RUN: begin
                        ck <= src_lvl[cr] && !of && (gc != OUT_RSVD);
                        if (rq != cr) begin
                            st <= SW_STOP;
                            cnt <= '0;
                        end
                    end
                    SW_STOP: begin
                        // a stuck-high clock must not deadlock the switch
                        if (!src_lvl[cr] || cnt == 6'(DET_WINDOW - 1)) begin
                            ck <= 1'b0;
                            st <= SW_HOLD;
                            cnt <= '0;
                        end else begin
                            cnt <= cnt + 1'b1;
                        end
                    end
                    SW_HOLD: begin
                        ck <= 1'b0;
                        if (cnt != 6'(SYNC_CYC - 1)) begin
                            cnt <= cnt + 1'b1;
                        end else if (!tgt_pll || pll_lock) begin
                            cr <= rq;
                            st <= SW_RUN;
                        end
                    end
                    default: begin
                        st <= SW_RUN;
                    end
                endcase
            end
        end

        stop_bound_a: assert property (
            (st == SW_STOP) |-> ##[1:32] (st != SW_STOP))
            else $error("switch stayed waiting for low too long");
        hold_low_a: assert property (
            (st == SW_HOLD) |=> (ck == 1'b0))
            else $error("clock not held low during switch");
        pll_lock_gate_a: assert property (
            (st == SW_HOLD ##1 st == SW_RUN && int'(cr) >= SRC_PLL0
                && int'(cr) <= SRC_PLL2) |-> $past(pll_lock))
            else $error("pll released before lock");
        keep_illegal_a: assert property (
            (wsel && !sel_ok(pwdata[SEL_W-1:0], IS_FD, present)) |=> $stable(rq))
            else $error("illegal select was stored");
    end

    fixed_ring_a: assert property (
        req_v[OUT_SAFE*SEL_W +: SEL_W] == SEL_W'(SRC_RING)
        && req_v[OUT_CTRL*SEL_W +: SEL_W] == SEL_W'(SRC_RING))
        else $error("safe or control output left the ring oscillator");
    rsvd_low_a: assert property (
        base_clk[OUT_RSVD] == 1'b0)
        else $error("reserved output toggled");
    reset_ring_a: assert property (
        $rose(pres_valid) |-> (req_v == '0))
        else $error("selector not on ring oscillator after reset");
    pres_blank_a: assert property (
        !pres_valid |-> (present == '0))
        else $error("presence reported before window elapsed");
    pd_lock_a: assert property (
        pll_power_down |=> !pll_lock)
        else $error("lock high while powered down");
    phase_sync_a: assert property (
        (pll_lock && extra_phase_enable) |=> pll_phase_sync)
        else $error("extra phases not synchronised after lock");
    evt_set_wins_a: assert property (
        (det_rise[SRC_XTAL]) |=> evt_rise[SRC_XTAL])
        else $error("activation event lost");
endmodule
`default_nettype wire

// ---- bench/bcg_testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import bcg_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_SRC-1:0] src_lvl = '0;
    logic [NUM_SRC-1:0] run_mask = '0;
    logic [NUM_SRC-1:0] high_mask = '0;
    logic usb_pll_ref_clk;
    logic usb_direct_clk;
    logic [NUM_OUT-1:0] base_clk;
    logic pll_power_down;
    logic pll_direct;
    logic [4:0] pll_post_div;
    logic [7:0] pll_fb_div;
    logic pll_lock;
    logic pll_phase_sync;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int total_checks = 0;
    int n;

    bcg_top #(.PLL_LOCK_US(1)) u_bcg_top (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .src_lvl(src_lvl),
        .base_clk(base_clk),
        .fdiv_in_clk(),
        .pll_ref_clk(),
        .pll_power_down(pll_power_down),
        .pll_direct(pll_direct),
        .pll_post_div(pll_post_div),
        .pll_fb_div(pll_fb_div),
        .pll_lock(pll_lock),
        .pll_phase_sync(pll_phase_sync),
        .usb_pll_ref_clk(usb_pll_ref_clk),
        .usb_direct_clk(usb_direct_clk)
    );

    // 200 mhz control clock
    always #2.5 ref_clk = ~ref_clk;

    // running sources toggle every cycle; a stopped source settles low, a stuck one high
    always @(posedge ref_clk) begin
        src_lvl <= ((src_lvl ^ run_mask) & run_mask) | high_mask;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; waits up to 50 cycles for pready
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        chk("pready", {31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string what, input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk(what, rd, exp);
    endtask

    function automatic logic [7:0] ch(input int i);
        return OFF_CH + 8'(4 * i);
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        conclude();
    end

    // main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        run_mask <= 12'hfe3;
        rdchk("presence early", OFF_PRES, 32'h0);
        rdchk("pll control reset", OFF_PLLCTL, 32'h0000_0101);
        for (int i = 0; i < 19; i++) begin
            rdchk("select reset", ch(i), 32'h0);
        end
        rdchk("presence", OFF_PRES, 32'h0001_0fe3);
        rdchk("activation events", OFF_EVT, 32'h0000_0fe3);
        apb(1'b1, OFF_EVT, 32'hffff_ffff);
        rdchk("events cleared", OFF_EVT, 32'h0);
        $display("test reset and presence done");
        // fixed channels refuse anything but the ring oscillator
        apb(1'b1, ch(OUT_SAFE), 32'h1);
        rdchk("safe select", ch(OUT_SAFE), 32'h0);
        apb(1'b1, ch(OUT_CTRL), 32'h1);
        rdchk("control select", ch(OUT_CTRL), 32'h0);
        apb(1'b1, ch(OUT_SYS), 32'h1);
        repeat (50) @(posedge ref_clk);
        rdchk("system on crystal", ch(OUT_SYS), 32'h1);
        apb(1'b1, ch(OUT_SYS), 32'h0000_0102);
        rdchk("absent pll kept", ch(OUT_SYS), 32'h0000_0101);
        apb(1'b1, ch(12), 32'h0000_0105);
        rdchk("divider fed by divider", ch(12), 32'h0000_0100);
        apb(1'b1, ch(13), 32'h1);
        repeat (50) @(posedge ref_clk);
        rdchk("divider on crystal", ch(13), 32'h1);
        $display("test selection done");
        // stop the crystal while it is selected
        run_mask <= 12'hfe1;
        repeat (40) @(posedge ref_clk);
        rdchk("presence crystal gone", OFF_PRES, 32'h0001_0fe1);
        rdchk("deactivation event", OFF_EVT, 32'h0002_0000);
        apb(1'b1, ch(3), 32'h1);
        rdchk("inactive select masked", ch(3), 32'h0);
        run_mask <= 12'hfe3;
        $display("test activity done");
        // a source stuck high must not stall a switch away from it
        apb(1'b1, ch(6), 32'h7);
        repeat (10) @(posedge ref_clk);
        high_mask <= 12'h080;
        repeat (4) @(posedge ref_clk);
        apb(1'b1, ch(6), 32'h0);
        rdchk("switch waiting", ch(6), 32'h0001_0000);
        repeat (31) @(posedge ref_clk);
        chk("forced low", {31'h0, base_clk[6]}, 32'h0);
        repeat (10) @(posedge ref_clk);
        rdchk("switch done", ch(6), 32'h0);
        high_mask <= '0;
        $display("test stuck switch done");
        // the divisor output lags the control register by one registered stage
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, OFF_PLLCTL, 32'h0000_0501 | (k << PSEL_LSB));
            repeat (2) @(posedge ref_clk);
            chk("post divide", {27'h0, pll_post_div}, 32'h2 << k);
        end
        apb(1'b1, OFF_PLLCTL, 32'h0000_0503);
        repeat (2) @(posedge ref_clk);
        chk("direct divide", {27'h0, pll_post_div}, 32'h1);
        chk("direct bit", {31'h0, pll_direct}, 32'h1);
        chk("feedback factor", {24'h0, pll_fb_div}, 32'h5);
        chk("held low in power-down", {31'h0, pll_lock}, 32'h0);
        apb(1'b1, OFF_PLLCTL, 32'h0000_0510);
        n = 0;
        while (pll_lock !== 1'b1 && n < 1000) begin
            @(posedge ref_clk);
            n++;
        end
        chk("lock delay near 200", 32'(n >= 195 && n <= 205), 32'h1);
        repeat (2) @(posedge ref_clk);
        chk("phase sync", {31'h0, pll_phase_sync}, 32'h1);
        rdchk("pll status", OFF_PLLSTS, 32'h3);
        run_mask <= 12'hfff;
        repeat (40) @(posedge ref_clk);
        apb(1'b1, ch(4), 32'h2);
        repeat (50) @(posedge ref_clk);
        rdchk("output on pll", ch(4), 32'h2);
        apb(1'b1, OFF_PLLCTL, 32'h0000_0511);
        repeat (2) @(posedge ref_clk);
        chk("lock lost", {31'h0, pll_lock}, 32'h0);
        $display("test pll done");
        apb(1'b1, OFF_USB, 32'h1);
        rdchk("usb feed select", OFF_USB, 32'h1);
        // feed clocks reach the usb unit one cycle after the base outputs
        for (int k = 0; k < 2; k++) begin
            rd[0] = base_clk[OUT_FEED_A];
            rd[1] = base_clk[OUT_FEED_B];
            @(posedge ref_clk);
            chk("usb direct clock", {31'h0, usb_direct_clk}, {31'h0, rd[0]});
            chk("usb pll reference", {31'h0, usb_pll_ref_clk}, {31'h0, rd[1]});
        end
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        chk("reserved output", {31'h0, base_clk[OUT_RSVD]}, 32'h0);
        $display("test misc done");
        conclude();
    end
endmodule
`default_nettype wire
